// *** shared/t16_map.svh ***
`ifndef T16_MAP_SVH
`define T16_MAP_SVH

// Register byte offsets, one aligned word each
`define T16_OFF_CTRL_A    8'h00
`define T16_OFF_CTRL_B    8'h04
`define T16_OFF_CNT_LO    8'h08
`define T16_OFF_CNT_HI    8'h0C
`define T16_OFF_CAP_LO    8'h10
`define T16_OFF_CAP_HI    8'h14
`define T16_OFF_CMPA_LO   8'h18
`define T16_OFF_CMPA_HI   8'h1C
`define T16_OFF_CMPB_LO   8'h20
`define T16_OFF_CMPB_HI   8'h24
`define T16_OFF_FLAGS     8'h28
`define T16_OFF_IRQ_EN    8'h2C
`define T16_OFF_COMP_CTRL 8'h30

// timer_control_a fields
`define T16_A_WGM_LO 1:0
// timer_control_b fields
`define T16_B_FILT   7
`define T16_B_EDGE   6
`define T16_B_WGM_HI 4:3
`define T16_B_CS     2:0
// Flag and enable bit positions
`define T16_F_OVF    0
`define T16_F_CAP    5
// comparator_control_status field
`define T16_C_CAPSEL 2

// Reset values
`define T16_RST_BYTE 8'h00
`define T16_RST_WORD 16'h0000

// Fixed top values, bottom and count step
`define T16_TOP_8B  16'h00FF
`define T16_TOP_9B  16'h01FF
`define T16_TOP_10B 16'h03FF
`define T16_MAX     16'hFFFF
`define T16_BOTTOM  16'h0000
`define T16_ONE     16'h0001

// Prescaler masks: tick when all masked bits are one
`define T16_PRE_1    10'h000
`define T16_PRE_8    10'h007
`define T16_PRE_64   10'h03F
`define T16_PRE_256  10'h0FF
`define T16_PRE_1024 10'h3FF

`endif

// *** shared/t16_pkg.sv ***
package t16_pkg;

  typedef enum logic {
    T16_UP,
    T16_DOWN
  } t16_dir_e;

  typedef enum logic [2:0] {
    T16_CS_STOP,
    T16_CS_DIV1,
    T16_CS_DIV8,
    T16_CS_DIV64,
    T16_CS_DIV256,
    T16_CS_DIV1024,
    T16_CS_EXT_FALL,
    T16_CS_EXT_RISE
  } t16_cs_e;

  typedef logic [15:0] t16_word_t;

endpackage

// *** rtl/t16_timer.sv ***
// Summary of operation
// - Counter high byte location reaches shared latch
// - Low-byte counter read copies high byte
// - Low-byte counter write loads all sixteen bits
// - Select zero gives no tick, counter stops
// - Counter readable and writable while stopped
// - Processor write beats clear or count
// - Waveform mode chooses clear, increment, decrement
// - Overflow flag per mode, raises interrupt
// - Matching trigger edge copies counter to capture
// - Capture flag set with the copy
// - Enabled capture flag requests interrupt, service clears
// - Writing one clears capture flag
// - Capture low read latches high byte
// - Capture writes only in capture-top modes
// - Select bit swaps pin for comparator
// - Source swap may capture; software clears flag
// - Filter changes after four equal samples
// - Filter enable bit, system clock, four cycles
// - Captures blocked in capture-top modes
// - New capture overwrites unread value
// - Port-driven capture pin level can capture
// - One latch shared by all wide registers
//
// The register addresses and register access over APB were decided locally.
`include "t16_map.svh"

module t16_timer #(
  parameter int FILT_LEN = 4,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_tick_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  input wire logic ovf_irq_ack,
  input wire logic cap_irq_ack,
  output logic ovf_irq,
  output logic cap_irq
);

  if (FILT_LEN < 2 || FILT_LEN > 16) begin : g_bad_filt
    $error("FILT_LEN must be 2..16");
  end
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  function automatic logic [15:0] top_of(input logic [3:0] m,
                                         input logic [15:0] a,
                                         input logic [15:0] c);
    case (m)
      4'h1, 4'h5: top_of = `T16_TOP_8B;
      4'h2, 4'h6: top_of = `T16_TOP_9B;
      4'h3, 4'h7: top_of = `T16_TOP_10B;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = a;
      4'h8, 4'hA, 4'hC, 4'hE: top_of = c;
      default: top_of = `T16_MAX;
    endcase
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    case (m)
      4'h8, 4'hA, 4'hC, 4'hE: cap_is_top = 1'b1;
      default: cap_is_top = 1'b0;
    endcase
  endfunction

  function automatic logic dual_slope(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: dual_slope = 1'b1;
      default: dual_slope = 1'b0;
    endcase
  endfunction

  function automatic logic fast_pwm(input logic [3:0] m);
    case (m)
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: fast_pwm = 1'b1;
      default: fast_pwm = 1'b0;
    endcase
  endfunction

  // Registers
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] comp_ctrl_q;
  logic [7:0] irq_en_q;
  logic [7:0] temp_q;
  t16_pkg::t16_word_t cnt_q;
  t16_pkg::t16_word_t cnt_d;
  t16_pkg::t16_word_t cap_q;
  t16_pkg::t16_word_t cmpa_q;
  t16_pkg::t16_word_t cmpb_q;
  t16_pkg::t16_dir_e dir_q;
  t16_pkg::t16_dir_e dir_d;
  logic ovf_flag_q;
  logic cap_flag_q;
  logic [9:0] pre_q;

  // Bus slave
  logic [7:0] addr;
  logic rd_fire;
  logic wr_fire;
  logic mapped;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;

  assign addr = paddr[7:0];
  assign wbyte = pwdata[7:0];
  // Reads sample and apply side effects on the first access edge
  assign rd_fire = psel & penable & ~pwrite & ~pready;
  // Writes take effect on the completing edge
  assign wr_fire = psel & penable & pwrite & pready;

  logic [3:0] wgm;
  logic [15:0] top;
  assign wgm = {ctrl_b_q[`T16_B_WGM_HI], ctrl_a_q[`T16_A_WGM_LO]};
  assign top = top_of(wgm, cmpa_q, cap_q);

  always_comb begin
    mapped = 1'b1;
    rd_byte = `T16_RST_BYTE;
    case (addr)
      `T16_OFF_CTRL_A: rd_byte = ctrl_a_q;
      `T16_OFF_CTRL_B: rd_byte = ctrl_b_q;
      `T16_OFF_CNT_LO: rd_byte = cnt_q[7:0];
      `T16_OFF_CNT_HI: rd_byte = temp_q;
      `T16_OFF_CAP_LO: rd_byte = cap_q[7:0];
      `T16_OFF_CAP_HI: rd_byte = temp_q;
      `T16_OFF_CMPA_LO: rd_byte = cmpa_q[7:0];
      `T16_OFF_CMPA_HI: rd_byte = cmpa_q[15:8];
      `T16_OFF_CMPB_LO: rd_byte = cmpb_q[7:0];
      `T16_OFF_CMPB_HI: rd_byte = cmpb_q[15:8];
      `T16_OFF_FLAGS: begin
        rd_byte[`T16_F_OVF] = ovf_flag_q;
        rd_byte[`T16_F_CAP] = cap_flag_q;
      end
      `T16_OFF_IRQ_EN: rd_byte = irq_en_q;
      `T16_OFF_COMP_CTRL: rd_byte = comp_ctrl_q;
      default: mapped = 1'b0;
    endcase
  end

  // One wait state, then pready for one cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_fire) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // Shared high-byte latch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      temp_q <= `T16_RST_BYTE;
    end else if (wr_fire && (addr == `T16_OFF_CNT_HI ||
                             addr == `T16_OFF_CAP_HI ||
                             addr == `T16_OFF_CMPA_HI ||
                             addr == `T16_OFF_CMPB_HI)) begin
      temp_q <= wbyte;
    end else if (rd_fire && addr == `T16_OFF_CNT_LO) begin
      temp_q <= cnt_q[15:8];
    end else if (rd_fire && addr == `T16_OFF_CAP_LO) begin
      temp_q <= cap_q[15:8];
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_a_q <= `T16_RST_BYTE;
      ctrl_b_q <= `T16_RST_BYTE;
      irq_en_q <= `T16_RST_BYTE;
      comp_ctrl_q <= `T16_RST_BYTE;
    end else if (wr_fire) begin
      case (addr)
        `T16_OFF_CTRL_A: ctrl_a_q <= wbyte;
        `T16_OFF_CTRL_B: ctrl_b_q <= wbyte;
        `T16_OFF_IRQ_EN: irq_en_q <= wbyte;
        `T16_OFF_COMP_CTRL: comp_ctrl_q <= wbyte;
        default: ;
      endcase
    end
  end

  // Compare registers, loaded whole on the low-byte write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmpa_q <= `T16_RST_WORD;
      cmpb_q <= `T16_RST_WORD;
    end else if (wr_fire && addr == `T16_OFF_CMPA_LO) begin
      cmpa_q <= {temp_q, wbyte};
    end else if (wr_fire && addr == `T16_OFF_CMPB_LO) begin
      cmpb_q <= {temp_q, wbyte};
    end
  end

  // Input synchronisers: tick pin, comparator, capture pin
  logic [2:0] raw_in;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  assign raw_in = {external_tick_pin, comparator_output, capture_input_pin};

  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        sync1_q[gi] <= 1'b0;
        sync2_q[gi] <= 1'b0;
      end else begin
        sync1_q[gi] <= raw_in[gi];
        sync2_q[gi] <= sync1_q[gi];
      end
    end
  end

  // Tick generation
  t16_pkg::t16_cs_e cs;
  logic ext_prev_q;
  logic tick;
  assign cs = t16_pkg::t16_cs_e'(ctrl_b_q[`T16_B_CS]);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pre_q <= 10'h000;
      ext_prev_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 10'h001;
      ext_prev_q <= sync2_q[2];
    end
  end

  always_comb begin
    case (cs)
      t16_pkg::T16_CS_DIV1: tick = 1'b1;
      t16_pkg::T16_CS_DIV8: tick = &(pre_q | ~`T16_PRE_8);
      t16_pkg::T16_CS_DIV64: tick = &(pre_q | ~`T16_PRE_64);
      t16_pkg::T16_CS_DIV256: tick = &(pre_q | ~`T16_PRE_256);
      t16_pkg::T16_CS_DIV1024: tick = &(pre_q | ~`T16_PRE_1024);
      t16_pkg::T16_CS_EXT_FALL: tick = ext_prev_q & ~sync2_q[2];
      t16_pkg::T16_CS_EXT_RISE: tick = ~ext_prev_q & sync2_q[2];
      default: tick = 1'b0;
    endcase
  end

  // Counter
  logic cnt_wr;
  logic ovf_set;
  assign cnt_wr = wr_fire && addr == `T16_OFF_CNT_LO;

  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    ovf_set = 1'b0;
    if (cnt_wr) begin
      cnt_d = {temp_q, wbyte};
    end else if (tick) begin
      if (dual_slope(wgm)) begin
        if (dir_q == t16_pkg::T16_UP) begin
          if (cnt_q >= top) begin
            dir_d = t16_pkg::T16_DOWN;
            cnt_d = cnt_q - `T16_ONE;
          end else begin
            cnt_d = cnt_q + `T16_ONE;
          end
        end else if (cnt_q == `T16_BOTTOM) begin
          dir_d = t16_pkg::T16_UP;
          cnt_d = cnt_q + `T16_ONE;
        end else begin
          cnt_d = cnt_q - `T16_ONE;
        end
        // Overflow on reaching bottom
        ovf_set = dir_q == t16_pkg::T16_DOWN && cnt_q == `T16_ONE;
      end else begin
        if (cnt_q == top) begin
          cnt_d = `T16_BOTTOM;
        end else begin
          cnt_d = cnt_q + `T16_ONE;
        end
        // Fast modes overflow at top, others at max
        ovf_set = fast_pwm(wgm) ? (cnt_q == top)
                                : (cnt_q == `T16_MAX);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= `T16_RST_WORD;
      dir_q <= t16_pkg::T16_UP;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  // Capture trigger path
  logic src;
  logic [FILT_LEN-1:0] samp_q;
  logic filt_q;
  logic trig;
  logic trig_prev_q;
  logic edge_hit;
  logic cap_fire;

  // Selected trigger source
  assign src = comp_ctrl_q[`T16_C_CAPSEL] ? sync2_q[1]
                                          : sync2_q[0];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      samp_q <= '0;
      filt_q <= 1'b0;
    end else begin
      samp_q <= {samp_q[FILT_LEN-2:0], src};
      if (&samp_q) begin
        filt_q <= 1'b1;
      end else if (~|samp_q) begin
        filt_q <= 1'b0;
      end
    end
  end

  assign trig = ctrl_b_q[`T16_B_FILT] ? filt_q : src;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig;
    end
  end

  // Edge select: one for rising, zero for falling
  assign edge_hit = ctrl_b_q[`T16_B_EDGE] ? (trig & ~trig_prev_q)
                                          : (~trig & trig_prev_q);
  assign cap_fire = edge_hit & ~cap_is_top(wgm);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cap_q <= `T16_RST_WORD;
    end else if (cap_fire) begin
      cap_q <= cnt_q;
    end else if (wr_fire && addr == `T16_OFF_CAP_LO &&
                 cap_is_top(wgm)) begin
      cap_q <= {temp_q, wbyte};
    end
  end

  // Flags: hardware set wins over clear
  logic flag_wr;
  assign flag_wr = wr_fire && addr == `T16_OFF_FLAGS;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cap_flag_q <= 1'b0;
    end else if (cap_fire) begin
      cap_flag_q <= 1'b1;
    end else if ((flag_wr && wbyte[`T16_F_CAP]) || cap_irq_ack) begin
      cap_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ovf_flag_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_flag_q <= 1'b1;
    end else if ((flag_wr && wbyte[`T16_F_OVF]) || ovf_irq_ack) begin
      ovf_flag_q <= 1'b0;
    end
  end

  // Interrupt requests, registered from the next flag state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cap_irq <= 1'b0;
      ovf_irq <= 1'b0;
    end else begin
      cap_irq <= irq_en_q[`T16_F_CAP] &
                 (cap_fire | (cap_flag_q & ~cap_irq_ack &
                  ~(flag_wr & wbyte[`T16_F_CAP])));
      ovf_irq <= irq_en_q[`T16_F_OVF] &
                 (ovf_set | (ovf_flag_q & ~ovf_irq_ack &
                  ~(flag_wr & wbyte[`T16_F_OVF])));
    end
  end

endmodule

// *** testbench/t16_timer_properties.sv ***
module t16_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  input wire logic cap_irq_ack,
  input wire logic cap_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pins_q;
  logic [3:0] pin_age_q;
  logic [2:0] bus_age_q;
  always_ff @(posedge clk) pins_q <= {capture_input_pin, comparator_output};
  // Quiet time on the trigger pins and on the bus, to tell causes apart
  always_ff @(posedge clk) begin
    if (!reset_n || pins_q != {capture_input_pin, comparator_output})
      pin_age_q <= 4'h0;
    else if (pin_age_q != 4'hF)
      pin_age_q <= pin_age_q + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (!reset_n || psel)
      bus_age_q <= 3'h0;
    else if (bus_age_q != 3'h7)
      bus_age_q <= bus_age_q + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_idle_quiet: assert property (!psel |=> !pready)
    else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_upper: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h000000) else $error("upper read bits set");
  a_rdata_hold: assert property (!(psel && penable && !pwrite) |=>
    $stable(prdata)) else $error("prdata moved without read");
  a_cap_cause: assert property ($rose(cap_irq) |->
    pin_age_q < 4'hE || bus_age_q < 3'h7) else $error("capture uncaused");
  a_ack_clears: assert property (cap_irq_ack && pin_age_q == 4'hF &&
    bus_age_q == 3'h7 |-> ##2 !cap_irq) else $error("ack left flag");
  cover property (pslverr);
  cover property ($rose(cap_irq));
  cover property (cap_irq_ack && cap_irq);
endmodule

// *** testbench/t16_cpu_model.sv ***
module t16_cpu_model (
  input wire logic clk,
  input wire logic svc_en,
  input wire logic cap_lvl,
  input wire logic cmp_lvl,
  input wire logic ovf_irq,
  input wire logic cap_irq,
  output logic capture_input_pin,
  output logic comparator_output,
  output logic external_tick_pin,
  output logic ovf_irq_ack,
  output logic cap_irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  assign external_tick_pin = 1'b0;
  initial begin
    capture_input_pin = 1'b0;
    comparator_output = 1'b0;
    ovf_irq_ack = 1'b0;
    cap_irq_ack = 1'b0;
  end
  // Port output register drives the trigger pin
  always @(posedge clk) begin
    capture_input_pin <= cap_lvl;
    comparator_output <= cmp_lvl;
  end
  // Interrupt service, one acknowledge per request
  always @(posedge clk) begin
    cap_irq_ack <= svc_en && cap_irq && !cap_irq_ack;
    ovf_irq_ack <= svc_en && ovf_irq && !ovf_irq_ack;
  end
endmodule

// *** testbench/t16_timer_bench.sv ***
`include "t16_map.svh"
module t16_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CB = `T16_OFF_CTRL_B, CL = `T16_OFF_CNT_LO,
    CH = `T16_OFF_CNT_HI, KL = `T16_OFF_CAP_LO, KH = `T16_OFF_CAP_HI,
    FL = `T16_OFF_FLAGS, IE = `T16_OFF_IRQ_EN,
    CC = `T16_OFF_COMP_CTRL, CA = `T16_OFF_CTRL_A;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, rd, v;
  logic [31:0] pwdata, prdata;
  logic svc_en, cap_lvl, cmp_lvl, ovf_irq, cap_irq, ovf_irq_ack;
  logic capture_input_pin, comparator_output, external_tick_pin;
  logic cap_irq_ack;
  int fail_count, n_compared, n;
  t16_timer t16_timer_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_tick_pin(external_tick_pin),
    .capture_input_pin(capture_input_pin),
    .comparator_output(comparator_output), .ovf_irq_ack(ovf_irq_ack),
    .cap_irq_ack(cap_irq_ack), .ovf_irq(ovf_irq), .cap_irq(cap_irq));
  t16_cpu_model t16_cpu_model_inst (.clk(clk), .svc_en(svc_en),
    .cap_lvl(cap_lvl), .cmp_lvl(cmp_lvl), .ovf_irq(ovf_irq),
    .cap_irq(cap_irq), .capture_input_pin(capture_input_pin),
    .comparator_output(comparator_output),
    .external_tick_pin(external_tick_pin), .ovf_irq_ack(ovf_irq_ack),
    .cap_irq_ack(cap_irq_ack));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic fail(input string m);
    fail_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail("no pready");
      summarize();
    end
    rd = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Sixteen-bit values go high byte first, then low byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    n_compared++;
    if (rd !== e) fail("read data mismatch");
  endtask
  task automatic cap(input logic c, input logic m, input logic e);
    logic seen;
    seen = 1'b0;
    cap_lvl <= c;
    cmp_lvl <= m;
    repeat (20) begin
      @(posedge clk);
      if (cap_irq === 1'b1) seen = 1'b1;
    end
    n_compared++;
    if (seen !== e) fail("capture mismatch");
  endtask
  task automatic service();
    // Quiet bus first, so the checker can watch the acknowledge alone
    repeat (8) @(posedge clk);
    svc_en <= 1'b1;
    repeat (12) @(posedge clk);
    chk(FL, 8'h00);
    svc_en <= 1'b0;
  endtask
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    svc_en = 1'b0;
    cap_lvl = 1'b0;
    cmp_lvl = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wr(CH, 8'h12);
    wr(CL, 8'h34);
    chk(CL, 8'h34);
    wr(CH, 8'hAB);
    chk(CL, 8'h34);
    chk(CH, 8'h12);
    wr(CH, 8'h5A);
    wr(`T16_OFF_CMPA_LO, 8'h01);
    wr(`T16_OFF_CMPB_LO, 8'h02);
    chk(`T16_OFF_CMPA_HI, 8'h5A);
    chk(`T16_OFF_CMPB_HI, 8'h5A);
    wr(IE, 8'h20);
    wr(CB, 8'h40);
    wr(CH, 8'h56);
    wr(CL, 8'h78);
    cap(1'b1, 1'b0, 1'b1);
    chk(KL, 8'h78);
    chk(KH, 8'h56);
    chk(FL, 8'h20);
    wr(FL, 8'h00);
    chk(FL, 8'h20);
    wr(FL, 8'h20);
    chk(FL, 8'h00);
    wr(CH, 8'h22);
    wr(CL, 8'h11);
    cap(1'b0, 1'b0, 1'b0);
    cap(1'b1, 1'b0, 1'b1);
    chk(KL, 8'h11);
    chk(KH, 8'h22);
    service();
    wr(CC, 8'h04);
    wr(FL, 8'h20);
    cap(1'b0, 1'b0, 1'b0);
    cap(1'b1, 1'b0, 1'b0);
    cap(1'b1, 1'b1, 1'b1);
    wr(CC, 8'h00);
    wr(FL, 8'h20);
    wr(CB, 8'hC0);
    cap(1'b0, 1'b1, 1'b0);
    cap_lvl <= 1'b1;
    repeat (2) @(posedge clk);
    cap(1'b0, 1'b1, 1'b0);
    cap(1'b1, 1'b1, 1'b1);
    wr(CB, 8'h18);
    wr(FL, 8'h20);
    wr(KH, 8'h9A);
    wr(KL, 8'hBC);
    chk(KL, 8'hBC);
    chk(KH, 8'h9A);
    cap(1'b0, 1'b1, 1'b0);
    wr(CB, 8'h00);
    wr(KH, 8'h33);
    wr(KL, 8'h44);
    chk(KL, 8'hBC);
    wr(CB, 8'h01);
    wr(CH, 8'h00);
    wr(CL, 8'h10);
    xfer(1'b0, CL, 8'h00);
    n_compared++;
    if (rd !== 8'h12) fail("count not running");
    wr(IE, 8'h21);
    wr(CH, 8'hFF);
    wr(CL, 8'hF0);
    n = 0;
    while (ovf_irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    n_compared++;
    if (n >= 200) begin
      fail("no overflow");
      summarize();
    end
    wr(CB, 8'h00);
    xfer(1'b0, CL, 8'h00);
    v = rd;
    chk(CL, v);
    // Divide by eight: 42 edges hold five or six ticks
    wr(CB, 8'h02);
    wr(CH, 8'h00);
    wr(CL, 8'h00);
    repeat (40) @(posedge clk);
    xfer(1'b0, CL, 8'h00);
    n_compared++;
    if (rd !== 8'h05 && rd !== 8'h06) fail("prescaled count wrong");
    // Dual slope, top 00FF: turns down after reaching top
    wr(CA, 8'h01);
    wr(CB, 8'h01);
    wr(CL, 8'hFE);
    chk(CL, 8'hFE);
    chk(CH, 8'h00);
    wr(CB, 8'h00);
    wr(CA, 8'h00);
    service();
    xfer(1'b0, 8'hFC, 8'h00);
    n_compared++;
    if (rerr !== 1'b1) fail("unmapped not refused");
    summarize();
  end
endmodule
bind t16_timer t16_checker t16_checker_inst (.clk(clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .capture_input_pin(capture_input_pin),
  .comparator_output(comparator_output), .cap_irq_ack(cap_irq_ack),
  .cap_irq(cap_irq));
